// ==== include/zgcc_cfg.svh ====
`ifndef ZGCC_CFG_SVH
`define ZGCC_CFG_SVH
`define ZGCC_NRZ_W 16
`define ZGCC_CODE_W 17
`define ZGCC_MAX_ZERO_RUN 6
`define ZGCC_ZONES 15
`define ZGCC_CYL_W 14
`define ZGCC_FIFO_DEPTH 8
`define ZGCC_HEAD_W 3
`define ZGCC_HEAD_CHANNELS 8
`define ZGCC_SER_FRAME_BITS 8
`define ZGCC_HEAD_RESET 3'h0
`define ZGCC_SCRAMBLE_PAT 16'h5555
`define ZGCC_STD_BOUNDS '{14'd1174, 14'd1760, 14'd2047, 14'd3600, 14'd4208, 14'd4830, 14'd5448, 14'd6630, \
    14'd7585, 14'd8485, 14'd9952, 14'd10960, 14'd11464, 14'd12464, 14'd13032}
`define ZGCC_BIG_BOUNDS '{14'd1302, 14'd1865, 14'd2148, 14'd3698, 14'd4295, 14'd4918, 14'd5538, 14'd6718, \
    14'd7670, 14'd8565, 14'd10022, 14'd11015, 14'd11494, 14'd12514, 14'd13032}
`endif

// ==== include/zgcc_pkg.sv ====
`include "zgcc_cfg.svh"
package zgcc_pkg;
    typedef logic [`ZGCC_NRZ_W-1:0] zgcc_nrz_type;
    typedef logic [`ZGCC_CODE_W-1:0] zgcc_code_type;
    typedef logic [`ZGCC_CYL_W-1:0] zgcc_cyl_type;
    typedef logic [3:0] zgcc_zone_type;
    typedef logic [`ZGCC_HEAD_W-1:0] zgcc_head_type;
    typedef logic [3:0] zgcc_run_type;
endpackage : zgcc_pkg

// ==== rtl/zgcc_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module zgcc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic full;
    } zgcc_fifo_state_type;

    zgcc_fifo_state_type st_ff;
    zgcc_fifo_state_type nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = ~st_ff.full;
    assign out_valid = (st_ff.count != '0);
    assign out_data = mem[st_ff.rd_ptr];
    assign push = in_valid & ~st_ff.full;
    assign pop = out_valid & out_ready;

    // pointers wrap at depth; full kept as its own flop so ready is clean
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
        end
        nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
        nxt_st.full = (nxt_st.count == (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // storage needs no reset; only entries below count are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_ff.wr_ptr] <= in_data;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!reset_n) st_ff.count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : zgcc_fifo
`default_nettype wire

// ==== rtl/zgcc_channel.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "zgcc_cfg.svh"
module zgcc_channel (
    input wire logic clk,
    input wire logic reset_n,
    input wire zgcc_pkg::zgcc_nrz_type wr_nrz_data,
    input wire logic wr_nrz_valid,
    output logic wr_nrz_ready,
    input wire logic write_clock_tick,
    input wire logic write_gate,
    output zgcc_pkg::zgcc_code_type wr_code,
    output logic wr_code_valid,
    output logic wr_code_run_error,
    input wire zgcc_pkg::zgcc_code_type rd_code,
    input wire logic rd_code_valid,
    output zgcc_pkg::zgcc_nrz_type rd_nrz_data,
    output logic rd_nrz_valid,
    input wire zgcc_pkg::zgcc_cyl_type cylinder,
    input wire logic large_variant,
    output zgcc_pkg::zgcc_zone_type zone,
    output logic zone_out_of_range,
    output logic zone_changed,
    output logic clock_from_synth,
    input wire logic serial_port_enable,
    input wire logic serial_port_clk,
    input wire logic serial_port_data,
    output zgcc_pkg::zgcc_head_type head_select,
    input wire logic head_short,
    input wire logic head_open,
    output logic write_fault_flag
);
    import zgcc_pkg::*;

    localparam zgcc_cyl_type STD_BOUNDS [`ZGCC_ZONES] = `ZGCC_STD_BOUNDS;
    localparam zgcc_cyl_type BIG_BOUNDS [`ZGCC_ZONES] = `ZGCC_BIG_BOUNDS;
    localparam zgcc_run_type MAX_RUN = 4'(`ZGCC_MAX_ZERO_RUN);

    typedef enum logic [0:0] {
        SER_IDLE = 1'b0,
        SER_SHIFT = 1'b1
    } zgcc_ser_state_type;

    typedef struct packed {
        zgcc_code_type wr_code;
        logic wr_code_valid;
        logic wr_code_run_error;
        zgcc_run_type tail_zeros;
        zgcc_nrz_type rd_nrz_data;
        logic rd_nrz_valid;
        zgcc_zone_type zone;
        logic zone_out_of_range;
        logic zone_changed;
        logic clock_from_synth;
        zgcc_ser_state_type ser_state;
        logic ser_clk_prev;
        logic [`ZGCC_SER_FRAME_BITS-1:0] ser_shift;
        logic [3:0] ser_count;
        zgcc_head_type head_select;
        logic write_fault_flag;
    } zgcc_state_type;

    zgcc_state_type st_ff;
    zgcc_state_type nxt_st;
    zgcc_nrz_type fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_ready;
    logic [`ZGCC_ZONES-1:0] std_hit;
    logic [`ZGCC_ZONES-1:0] big_hit;
    zgcc_code_type cand_plain;
    zgcc_code_type cand_flip;
    zgcc_code_type enc_code;
    logic enc_bad;

    ////////////////////////////////////////////////////////////////////////
    // write data buffer; back-pressure reaches the controller through ready
    zgcc_fifo #(
        .WIDTH(`ZGCC_NRZ_W),
        .DEPTH(`ZGCC_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(wr_nrz_data),
        .in_valid(wr_nrz_valid),
        .in_ready(fifo_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // a word leaves only on a write clock tick while the gate is open
    assign fifo_pop = write_gate & write_clock_tick;

    ////////////////////////////////////////////////////////////////////////
    // longest zero run check, including zeros carried over from the last word
    function automatic logic run_too_long(input zgcc_code_type c, input zgcc_run_type carry);
        zgcc_run_type run;
        logic bad;
        run = carry;
        bad = 1'b0;
        for (int i = `ZGCC_CODE_W - 1; i >= 0; i--) begin
            if (c[i]) begin
                run = '0;
            end else begin
                run = (run == 4'hf) ? run : run + 4'h1;
                bad = bad | (run > MAX_RUN);
            end
        end
        return bad;
    endfunction : run_too_long

    function automatic zgcc_run_type trailing_zeros(input zgcc_code_type c, input zgcc_run_type carry);
        zgcc_run_type run;
        run = carry;
        for (int i = `ZGCC_CODE_W - 1; i >= 0; i--) begin
            run = c[i] ? 4'h0 : ((run == 4'hf) ? run : run + 4'h1);
        end
        return run;
    endfunction : trailing_zeros

    // msb marks the form; the scrambled form is tried when the plain one breaks the run limit.
    // without the full code table some data patterns cannot be fixed, and those raise the run error
    assign cand_plain = {1'b1, fifo_data};
    assign cand_flip = {1'b0, fifo_data ^ `ZGCC_SCRAMBLE_PAT};
    always_comb begin
        enc_code = cand_plain;
        enc_bad = 1'b0;
        if (run_too_long(cand_plain, st_ff.tail_zeros)) begin
            enc_code = cand_flip;
            enc_bad = run_too_long(cand_flip, st_ff.tail_zeros);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // zone compare per bound; zone 0 starts at cylinder 0 on the outer edge
    generate
        for (genvar z = 0; z < `ZGCC_ZONES; z++) begin : g_zone
            assign std_hit[z] = (cylinder <= STD_BOUNDS[z]);
            assign big_hit[z] = (cylinder <= BIG_BOUNDS[z]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state for the codec, zone map, serial port and fault flag
    always_comb begin
        logic [`ZGCC_ZONES-1:0] hits;
        zgcc_zone_type found;
        logic none;
        hits = large_variant ? big_hit : std_hit;
        found = '0;
        none = 1'b1;
        nxt_st = st_ff;
        // encoder output
        nxt_st.wr_code_valid = fifo_pop & fifo_valid;
        if (fifo_pop && fifo_valid) begin
            nxt_st.wr_code = enc_code;
            nxt_st.wr_code_run_error = enc_bad;
            nxt_st.tail_zeros = trailing_zeros(enc_code, st_ff.tail_zeros);
        end
        if (!write_gate) begin
            nxt_st.tail_zeros = '0;
        end
        // decoder: the form bit tells whether to undo the scramble
        nxt_st.rd_nrz_valid = rd_code_valid;
        if (rd_code_valid) begin
            nxt_st.rd_nrz_data = rd_code[`ZGCC_CODE_W-1] ? rd_code[`ZGCC_NRZ_W-1:0]
                : rd_code[`ZGCC_NRZ_W-1:0] ^ `ZGCC_SCRAMBLE_PAT;
        end
        // lowest zone whose upper bound covers the cylinder wins
        for (int z = `ZGCC_ZONES - 1; z >= 0; z--) begin
            if (hits[z]) begin
                found = 4'(z);
                none = 1'b0;
            end
        end
        nxt_st.zone_out_of_range = none;
        nxt_st.zone = none ? st_ff.zone : found;
        nxt_st.zone_changed = ~none & (found != st_ff.zone);
        // clock source follows the write gate
        nxt_st.clock_from_synth = write_gate;
        // serial head-select port, bits shifted on the port clock rising edge
        nxt_st.ser_clk_prev = serial_port_clk;
        unique case (st_ff.ser_state)
            SER_IDLE: begin
                nxt_st.ser_count = '0;
                if (serial_port_enable) begin
                    nxt_st.ser_state = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                if (serial_port_clk && !st_ff.ser_clk_prev && st_ff.ser_count != 4'(`ZGCC_SER_FRAME_BITS)) begin
                    nxt_st.ser_shift = {st_ff.ser_shift[`ZGCC_SER_FRAME_BITS-2:0], serial_port_data};
                    nxt_st.ser_count = st_ff.ser_count + 4'h1;
                end
                if (!serial_port_enable) begin
                    nxt_st.ser_state = SER_IDLE;
                    // a short frame or a head beyond the fitted channels is ignored
                    if (st_ff.ser_count == 4'(`ZGCC_SER_FRAME_BITS)
                            && 32'(st_ff.ser_shift[`ZGCC_HEAD_W-1:0]) < `ZGCC_HEAD_CHANNELS) begin
                        nxt_st.head_select = st_ff.ser_shift[`ZGCC_HEAD_W-1:0];
                    end
                end
            end
        endcase
        // fault only counts while writing
        nxt_st.write_fault_flag = write_gate & (head_short | head_open);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs come straight from state flops, except fifo ready which is the inverse of its full flop
    assign wr_nrz_ready = fifo_ready;
    assign wr_code = st_ff.wr_code;
    assign wr_code_valid = st_ff.wr_code_valid;
    assign wr_code_run_error = st_ff.wr_code_run_error;
    assign rd_nrz_data = st_ff.rd_nrz_data;
    assign rd_nrz_valid = st_ff.rd_nrz_valid;
    assign zone = st_ff.zone;
    assign zone_out_of_range = st_ff.zone_out_of_range;
    assign zone_changed = st_ff.zone_changed;
    assign clock_from_synth = st_ff.clock_from_synth;
    assign head_select = st_ff.head_select;
    assign write_fault_flag = st_ff.write_fault_flag;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence word_taken_s;
        write_gate && write_clock_tick && fifo_valid;
    endsequence
    sequence frame_end_s;
        st_ff.ser_state == SER_SHIFT && !serial_port_enable && st_ff.ser_count == 4'h8;
    endsequence

    enc_pass_a: assert property (word_taken_s |=> wr_code_valid &&
        wr_code[15:0] == (wr_code[16] ? $past(fifo_data) : $past(fifo_data) ^ 16'h5555))
        else $error("encoded word does not match taken data");
    enc_idle_a: assert property (!(write_gate && write_clock_tick) |=> !wr_code_valid)
        else $error("code word without write clock tick");
    dec_pass_a: assert property (rd_code_valid |=> rd_nrz_valid &&
        rd_nrz_data == ($past(rd_code[16]) ? $past(rd_code[15:0]) : $past(rd_code[15:0]) ^ 16'h5555))
        else $error("decoded word wrong");
    run_limit_a: assert property (wr_code_valid && !wr_code_run_error |->
        !run_too_long(wr_code, $past(st_ff.tail_zeros)))
        else $error("zero run over limit without error");
    zone_std_a: assert property (!large_variant && cylinder == 14'd1175 |=> zone == 4'h1)
        else $error("standard zone bound wrong");
    zone_big_a: assert property (large_variant && cylinder == 14'd6718 |=> zone == 4'h7)
        else $error("large zone bound wrong");
    zone_range_a: assert property (cylinder > 14'd13032 |=> zone_out_of_range && $stable(zone))
        else $error("out of range cylinder chose a zone");
    zone_zero_a: assert property (cylinder == 14'd0 |=> zone == 4'h0 && !zone_out_of_range)
        else $error("cylinder zero not in zone zero");
    head_load_a: assert property (frame_end_s |=> head_select == $past(st_ff.ser_shift[2:0]))
        else $error("head not loaded at frame end");
    fault_a: assert property (write_gate && (head_short || head_open) |=> write_fault_flag)
        else $error("write fault not flagged");
    clk_src_a: assert property (write_gate [*2] |=> clock_from_synth)
        else $error("write clock not from synthesizer");
endmodule : zgcc_channel
`default_nettype wire

// ==== sim/zgcc_serial_host.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// processor end of the serial port: one frame per go, msb first
// zone rate and filter setup words travel in the same framing; only head frames reach this block
module zgcc_serial_host (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] frame,
    input wire logic [3:0] nbits,
    output logic busy = 1'b0,
    output logic port_enable = 1'b0,
    output logic port_clk = 1'b0,
    output logic port_data = 1'b0
);
    // idle data flips every cycle so a stale bit never passes for a real one
    always begin
        @(posedge clk);
        if (!go) begin
            port_data <= ~port_data;
        end else begin
            busy <= 1'b1;
            port_enable <= 1'b1;
            @(posedge clk);
            for (int i = 0; i < 32'(nbits); i++) begin
                port_data <= frame[7 - i];
                @(posedge clk);
                port_clk <= 1'b1;
                @(posedge clk);
                port_clk <= 1'b0;
                @(posedge clk);
            end
            port_enable <= 1'b0;
            port_data <= ~port_data;
            @(posedge clk);
            busy <= 1'b0;
        end
    end
endmodule : zgcc_serial_host
`default_nettype wire

// ==== sim/tb_zoned_gcr_codec_channel_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "zgcc_cfg.svh"
module tb_zoned_gcr_codec_channel_ctl;
    import zgcc_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    zgcc_nrz_type wr_nrz_data = '0;
    logic wr_nrz_valid = 1'b0;
    logic write_clock_tick = 1'b0;
    logic write_gate = 1'b0;
    zgcc_code_type rd_code = '0;
    logic rd_code_valid = 1'b0;
    zgcc_cyl_type cylinder = '0;
    logic large_variant = 1'b0;
    logic head_short = 1'b0;
    logic head_open = 1'b0;
    logic ser_go = 1'b0;
    logic [7:0] ser_frame = 8'h00;
    logic [3:0] ser_bits = 4'h8;
    logic wr_nrz_ready, wr_code_valid, wr_code_run_error, rd_nrz_valid, zone_out_of_range, zone_changed;
    logic clock_from_synth, serial_port_enable, serial_port_clk, serial_port_data, ser_busy, write_fault_flag;
    zgcc_code_type wr_code;
    zgcc_nrz_type rd_nrz_data;
    zgcc_zone_type zone;
    zgcc_head_type head_select;
    zgcc_nrz_type exp_q[$];
    zgcc_cyl_type bounds[2][15] = '{`ZGCC_STD_BOUNDS, `ZGCC_BIG_BOUNDS};
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int carry = 0;

    zgcc_channel u_dut (.clk, .reset_n, .wr_nrz_data, .wr_nrz_valid, .wr_nrz_ready, .write_clock_tick,
        .write_gate, .wr_code, .wr_code_valid, .wr_code_run_error, .rd_code, .rd_code_valid, .rd_nrz_data,
        .rd_nrz_valid, .cylinder, .large_variant, .zone, .zone_out_of_range, .zone_changed, .clock_from_synth,
        .serial_port_enable, .serial_port_clk, .serial_port_data, .head_select, .head_short, .head_open,
        .write_fault_flag);
    zgcc_serial_host u_host (.clk, .go(ser_go), .frame(ser_frame), .nbits(ser_bits), .busy(ser_busy),
        .port_enable(serial_port_enable), .port_clk(serial_port_clk), .port_data(serial_port_data));

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock and a hang guard well above the few hundred cycles needed
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // 15 stands for a cylinder beyond the last bound
    function automatic logic [4:0] exp_zone(input zgcc_cyl_type c, input logic big);
        for (int i = 0; i < 15; i++) begin
            if (c <= bounds[big][i]) return 5'(i);
        end
        return 5'h0f;
    endfunction : exp_zone

    // any seven zeros inside one word already break the limit, whatever was carried in
    function automatic logic long_run(input zgcc_code_type c);
        int run = 0;
        for (int i = 16; i >= 0; i--) begin
            run = c[i] ? 0 : run + 1;
            if (run > 6) return 1'b1;
        end
        return 1'b0;
    endfunction : long_run

    // zeros left at the end of a word, counting those carried in; over marks a run above six
    function automatic int zero_tail(input zgcc_code_type c, input int cin, output logic over);
        int run;
        run = cin;
        over = 1'b0;
        for (int i = 16; i >= 0; i--) begin
            run = c[i] ? 0 : run + 1;
            if (run > `ZGCC_MAX_ZERO_RUN) over = 1'b1;
        end
        return run;
    endfunction : zero_tail

    // entered at an edge; valid stays up so calls can run back to back
    task automatic push(input zgcc_nrz_type d, output logic acc);
        wr_nrz_valid <= 1'b1;
        wr_nrz_data <= d;
        #1;
        acc = wr_nrz_ready;
        @(posedge clk);
        if (acc) exp_q.push_back(d);
    endtask : push

    // one write clock period; the bench tracks the zeros carried from word to word
    task automatic tick();
        zgcc_nrz_type d;
        zgcc_code_type ec;
        logic over_p;
        logic over_f;
        write_clock_tick <= 1'b1;
        @(posedge clk);
        write_clock_tick <= 1'b0;
        #1;
        check(clock_from_synth, write_gate);
        check(wr_code_valid, exp_q.size() > 0);
        if (exp_q.size() > 0) begin
            d = exp_q.pop_front();
            // plain form first; the scrambled form only when the plain one breaks the limit
            void'(zero_tail({1'b1, d}, carry, over_p));
            void'(zero_tail({1'b0, d ^ `ZGCC_SCRAMBLE_PAT}, carry, over_f));
            ec = over_p ? {1'b0, d ^ `ZGCC_SCRAMBLE_PAT} : {1'b1, d};
            check(wr_code, ec);
            check(wr_code_run_error, over_p & over_f);
            check(long_run(wr_code) & !wr_code_run_error, 1'b0);
            carry = zero_tail(ec, carry, over_p);
        end
        @(posedge clk);
    endtask : tick

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic acc;
        zgcc_cyl_type c;
        zgcc_code_type rc;
        logic [7:0] fr;
        logic [4:0] ez;
        zgcc_zone_type pz;
        zgcc_head_type eh;
        void'($urandom(87343));
        repeat (7) @(posedge clk);
        #1;
        check({wr_nrz_ready, head_select, zone, write_fault_flag, wr_code_valid}, 10'h200);
        @(posedge clk);
        reset_n <= 1'b1;
        // gate shut: nothing drains, so the ninth and tenth words are refused
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            // 16'h0055 breaks the zero limit in both forms and must raise the run error
            push((i == 0) ? 16'h0000 : (i == 1) ? 16'h5555 : (i == 2) ? 16'h0055 : 16'($urandom), acc);
            check(acc, i < 8);
        end
        wr_nrz_valid <= 1'b0;
        write_gate <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++) tick();
        // with no write clock tick a waiting word must stay put
        push(16'h1234, acc);
        check(acc, 1'b1);
        wr_nrz_valid <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            #1;
            check(wr_code_valid, 1'b0);
        end
        @(posedge clk);
        tick();
        for (int i = 0; i < 40; i++) begin
            if ($urandom % 4 != 0) push(16'($urandom), acc);
            wr_nrz_valid <= 1'b0;
            tick();
        end
        // fault only counts while writing, and follows the head one cycle late
        head_short <= 1'b1;
        @(posedge clk);
        #1;
        check(write_fault_flag, 1'b1);
        @(posedge clk);
        head_short <= 1'b0;
        head_open <= 1'b1;
        @(posedge clk);
        write_gate <= 1'b0;
        #1;
        check(write_fault_flag, 1'b1);
        @(posedge clk);
        #1;
        check({write_fault_flag, clock_from_synth}, 2'b00);
        // every zone edge of both variants, one past it, and random cylinders
        pz = 4'h0;
        for (int v = 0; v < 2; v++) begin
            for (int j = 0; j < 45; j++) begin
                c = (j % 3 == 0) ? bounds[v][j / 3] : (j % 3 == 1) ? bounds[v][j / 3] + 14'd1 :
                    (j < 3) ? 14'h0000 : 14'($urandom % 14000);
                @(posedge clk);
                cylinder <= c;
                large_variant <= v[0];
                @(posedge clk);
                #1;
                ez = exp_zone(c, v[0]);
                if (ez == 5'h0f) begin
                    check({zone, zone_out_of_range, zone_changed}, {pz, 2'b10});
                end else begin
                    check({zone, zone_out_of_range}, {ez[3:0], 1'b0});
                    check(zone_changed, ez[3:0] != pz);
                    pz = ez[3:0];
                end
            end
        end
        // read words in both forms, all zeros and all ones among them
        for (int i = 0; i < 20; i++) begin
            rc = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1ffff : 17'($urandom);
            @(posedge clk);
            rd_code <= rc;
            rd_code_valid <= 1'b1;
            @(posedge clk);
            #1;
            check({rd_nrz_valid, rd_nrz_data}, {1'b1, rc[16] ? rc[15:0] : rc[15:0] ^ `ZGCC_SCRAMBLE_PAT});
        end
        @(posedge clk);
        rd_code_valid <= 1'b0;
        // head frames; the last one is a bit short and must be ignored
        eh = 3'h0;
        for (int i = 0; i < 6; i++) begin
            fr = 8'($urandom);
            if (i == 5) fr[3:1] = ~eh; // a wrongly taken short frame would land a different head
            @(posedge clk);
            ser_frame <= fr;
            ser_bits <= (i == 5) ? 4'h7 : 4'h8;
            ser_go <= 1'b1;
            @(posedge clk);
            ser_go <= 1'b0;
            for (int w = 0; w < 100 && (w < 2 || ser_busy); w++) begin
                @(posedge clk);
                #1;
            end
            repeat (3) @(posedge clk);
            #1;
            if (i < 5) eh = fr[2:0];
            check(head_select, eh);
        end
        complete_run();
    end
endmodule : tb_zoned_gcr_codec_channel_ctl
`default_nettype wire
